// ### tca_pkg.sv
// Constants and types for the Type-C attach and PHY enable logic.
// Assumes one core clock; all indication pins arrive asynchronously.
package tca_pkg;

  // Pin group widths and synchroniser stage count
  localparam int unsigned ATT_W  = 3;
  localparam int unsigned ORI_W  = 2;
  localparam int unsigned SIDE_W = 2;
  localparam int unsigned PHY_W  = 2;
  localparam int unsigned SYNC_STAGES = 2;

  // Bit positions inside the gathered pin vector
  localparam int unsigned POS_ATT  = 0;
  localparam int unsigned POS_ORI  = 3;
  localparam int unsigned POS_SA   = 5;
  localparam int unsigned POS_SB   = 7;
  localparam int unsigned POS_MODE = 9;
  localparam int unsigned POS_POL  = 10;
  localparam int unsigned POS_EXT  = 11;
  localparam int unsigned IN_W     = 12;

  // Receptacle configurations, three and only three
  typedef enum logic [1:0] {
    CFG_EXT   = 2'b00,
    CFG_MODE1 = 2'b01,
    CFG_MODE2 = 2'b10
  } tca_cfg_t;

  localparam logic [PHY_W-1:0] PHY_NONE = 2'h0;
  localparam logic [PHY_W-1:0] PHY_A    = 2'h1;
  localparam logic [PHY_W-1:0] PHY_B    = 2'h2;
  localparam logic [IN_W-1:0]  SYNC_RST = 12'h000;

endpackage

// ### tca_attach_ctrl.sv
// Type-C attach decode: turns port-controller indications into PHY enables
// and a PHY clock gate. Assumes all indication pins are asynchronous to clk_i
// and that an external port controller watches the receptacle.
`timescale 1ns/1ps

module tca_attach_ctrl
  import tca_pkg::*;
(
  input  wire logic                         clk_i,                      // Core clock
  input  wire logic                         rst_n_i,                    // Async reset
  input  wire logic [tca_pkg::ATT_W-1:0]    attach_detect_i,            // Attach pins
  input  wire logic [tca_pkg::ORI_W-1:0]    plug_orientation_in_i,      // Orientation pins
  input  wire logic [tca_pkg::SIDE_W-1:0]   mux_attach_side_in_a_i,     // Side A attach
  input  wire logic [tca_pkg::SIDE_W-1:0]   mux_attach_side_in_b_i,     // Side B attach
  input  wire logic                         internal_mux_mode_select_i, // High: mode 2
  input  wire logic                         indication_polarity_select_i, // High: active high
  input  wire logic                         ext_mux_config_i,           // High: external mux
  output logic      [tca_pkg::PHY_W-1:0]    phy_en_o,                   // PHY enables
  output logic                              phy_clk_en_o,               // PHY clock gate
  output logic                              attach_valid_o,             // Valid attach seen
  output logic                              orientation_b_o,            // Flipped plug
  output logic      [1:0]                   cfg_mode_o                  // Active configuration
);
  import tca_pkg::*;

  logic [IN_W-1:0]  raw_w;
  logic [IN_W-1:0]  sync1_r;
  logic [IN_W-1:0]  sync2_r;
  logic [IN_W-1:0]  sync1_nxt;
  logic [IN_W-1:0]  sync2_nxt;
  logic [IN_W-1:0]  norm_w;
  tca_cfg_t         cfg_r;
  tca_cfg_t         cfg_nxt;
  logic [PHY_W-1:0] phy_r;
  logic [PHY_W-1:0] phy_nxt;
  logic             clk_en_r;
  logic             clk_en_nxt;
  logic             valid_r;
  logic             valid_nxt;
  logic             orient_r;
  logic             orient_nxt;

  // Gather every pin into one vector so one loop synchronises them all
  assign raw_w = {ext_mux_config_i, indication_polarity_select_i,
                  internal_mux_mode_select_i, mux_attach_side_in_b_i,
                  mux_attach_side_in_a_i, plug_orientation_in_i, attach_detect_i};

  // Two-flop synchronisers, one per pin; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      always_comb begin
        sync1_nxt[gi] = raw_w[gi];
        sync2_nxt[gi] = sync1_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Fold polarity in once; the controller owns pin levels, we only reinterpret
  // them. Polarity itself and the two config straps are never inverted.
  always_comb begin
    norm_w = sync2_r;
    norm_w[POS_MODE-1:0] = sync2_r[POS_MODE-1:0] ^ {POS_MODE{~sync2_r[POS_POL]}};
  end

  // Decode configuration and attach into PHY enables
  always_comb begin
    logic att1;
    logic ori_a;
    logic ori_b;
    logic side_a;
    logic side_b;
    att1   = |norm_w[POS_ATT +: 2];
    ori_a  = norm_w[POS_ORI] & ~norm_w[POS_ORI+1];
    ori_b  = norm_w[POS_ORI+1] & ~norm_w[POS_ORI];
    side_a = |norm_w[POS_SA +: SIDE_W];
    side_b = |norm_w[POS_SB +: SIDE_W];
    if (norm_w[POS_EXT]) begin
      cfg_nxt = CFG_EXT;
    end else if (norm_w[POS_MODE]) begin
      cfg_nxt = CFG_MODE2;
    end else begin
      cfg_nxt = CFG_MODE1;
    end
    valid_nxt  = 1'b0;
    orient_nxt = 1'b0;
    phy_nxt    = PHY_NONE;
    case (cfg_nxt)
      CFG_EXT: begin
        // External mux does the steering; only the single PHY lane is used
        valid_nxt = |norm_w[POS_ATT +: ATT_W];
        phy_nxt   = valid_nxt ? PHY_A : PHY_NONE;
      end
      CFG_MODE1: begin
        // Ambiguous orientation (none or both) enables nothing
        valid_nxt  = att1 & (ori_a | ori_b);
        orient_nxt = att1 & ori_b;
        phy_nxt    = {att1 & ori_b, att1 & ori_a};
      end
      CFG_MODE2: begin
        // Both sides claiming attach is treated as no attach
        valid_nxt  = side_a ^ side_b;
        orient_nxt = side_b & ~side_a;
        phy_nxt    = {side_b & ~side_a, side_a & ~side_b};
      end
      default: begin
        phy_nxt = PHY_NONE;
      end
    endcase
    clk_en_nxt = |phy_nxt;
  end

  // Register the decode so the PHY sees glitch-free enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r    <= CFG_MODE1;
      phy_r    <= PHY_NONE;
      clk_en_r <= 1'b0;
      valid_r  <= 1'b0;
      orient_r <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      phy_r    <= phy_nxt;
      clk_en_r <= clk_en_nxt;
      valid_r  <= valid_nxt;
      orient_r <= orient_nxt;
    end
  end

  assign phy_en_o        = phy_r;
  assign phy_clk_en_o    = clk_en_r;
  assign attach_valid_o  = valid_r;
  assign orientation_b_o = orient_r;
  assign cfg_mode_o      = cfg_r;

  // Checks: pins sampled at one edge appear at the outputs three edges later
  logic [IN_W-1:0] chk_norm_w;
  always_comb begin
    chk_norm_w = raw_w;
    chk_norm_w[POS_MODE-1:0] = raw_w[POS_MODE-1:0] ^ {POS_MODE{~raw_w[POS_POL]}};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ext_on;
    raw_w[POS_EXT] && (|chk_norm_w[POS_ATT +: ATT_W]);
  endsequence
  sequence s_ext_off;
    raw_w[POS_EXT] && !(|chk_norm_w[POS_ATT +: ATT_W]);
  endsequence
  sequence s_mode1;
    !raw_w[POS_EXT] && !raw_w[POS_MODE];
  endsequence
  sequence s_mode2;
    !raw_w[POS_EXT] && raw_w[POS_MODE];
  endsequence

  chk_cfg_three: assert property (cfg_mode_o != 2'h3)
    else $error("Configuration outside the three supported");
  chk_ext_clk_on: assert property (s_ext_on ##3 1 |-> phy_clk_en_o && phy_en_o == PHY_A)
    else $error("External mux attach did not enable the PHY clock");
  chk_ext_clk_off: assert property (s_ext_off ##3 1 |-> !phy_clk_en_o && !attach_valid_o)
    else $error("PHY clock running without attach");
  chk_pol_low_att: assert property (raw_w[POS_EXT] && !raw_w[POS_POL]
      && attach_detect_i == 3'h0 ##3 1 |-> phy_clk_en_o)
    else $error("Active-low attach not recognised");
  chk_mode1_pick: assert property (s_mode1 ##3 1 |-> cfg_mode_o == CFG_MODE1)
    else $error("Mode select low did not give mode 1");
  chk_mode1_side_a: assert property (s_mode1 ##0 (|chk_norm_w[POS_ATT +: 2])
      && chk_norm_w[POS_ORI +: ORI_W] == 2'h1 ##3 1
      |-> phy_en_o == PHY_A && !orientation_b_o && attach_valid_o)
    else $error("Mode 1 orientation A decode wrong");
  chk_mode2_side_b: assert property (s_mode2 ##0 !(|chk_norm_w[POS_SA +: SIDE_W])
      && (|chk_norm_w[POS_SB +: SIDE_W]) ##3 1
      |-> cfg_mode_o == CFG_MODE2 && phy_en_o == PHY_B && orientation_b_o)
    else $error("Mode 2 side B decode wrong");
  chk_phy_unused_off: assert property ($onehot0(phy_en_o)
      && (attach_valid_o || (phy_en_o == PHY_NONE && !phy_clk_en_o)))
    else $error("Unused PHY left enabled");
  chk_sync_lag: assert property (s_ext_off [*3] ##1 s_ext_on |=> !phy_clk_en_o [*2])
    else $error("Attach reached the PHY before two sync stages");

  // Side patterns of mode 2 and orientation B of mode 1; a tie on both sides must enable nothing
  sequence s_side_a_only;
    s_mode2 ##0 (|chk_norm_w[POS_SA +: SIDE_W]) && !(|chk_norm_w[POS_SB +: SIDE_W]);
  endsequence
  sequence s_side_tie;
    s_mode2 ##0 (|chk_norm_w[POS_SA +: SIDE_W]) == (|chk_norm_w[POS_SB +: SIDE_W]);
  endsequence
  sequence s_mode1_b;
    s_mode1 ##0 (|chk_norm_w[POS_ATT +: 2]) && chk_norm_w[POS_ORI +: ORI_W] == 2'h2;
  endsequence

  // The clock gate is registered apart from the enables, so check they agree
  chk_clk_track: assert property (phy_clk_en_o == (|phy_en_o))
    else $error("PHY clock gate disagrees with PHY enables");
  chk_mode1_side_b: assert property (s_mode1_b ##3 1
      |-> phy_en_o == PHY_B && orientation_b_o && attach_valid_o)
    else $error("Mode 1 orientation B decode wrong");
  chk_mode2_side_a: assert property (s_side_a_only ##3 1
      |-> cfg_mode_o == CFG_MODE2 && phy_en_o == PHY_A && !orientation_b_o)
    else $error("Mode 2 side A decode wrong");
  chk_mode2_tie_off: assert property (s_side_tie ##3 1
      |-> phy_en_o == PHY_NONE && !attach_valid_o && !phy_clk_en_o)
    else $error("Mode 2 tie left a PHY enabled");

endmodule

// ### tca_pc_model.sv
// Model of the external port controller that watches the receptacle.
// Assumes the bench hands it the logical attach and orientation states.
`timescale 1ns/1ps
module tca_pc_model (
  input  wire logic       pol_i,  // Active level of indications
  input  wire logic [2:0] att_i,  // Logical attach
  input  wire logic [1:0] ori_i,  // Logical orientation
  input  wire logic [1:0] sa_i,   // Logical side A attach
  input  wire logic [1:0] sb_i,   // Logical side B attach
  output logic      [2:0] att_o,  // Attach pins
  output logic      [1:0] ori_o,  // Orientation pins
  output logic      [1:0] sa_o,   // Side A pins
  output logic      [1:0] sb_o    // Side B pins
);
  // Pins follow the level chosen by the polarity pin, so low-active runs invert all
  always_comb begin
    att_o = pol_i ? att_i : ~att_i;
    ori_o = pol_i ? ori_i : ~ori_i;
    sa_o  = pol_i ? sa_i : ~sa_i;
    sb_o  = pol_i ? sb_i : ~sb_i;
  end
endmodule

// ### typec_attach_phy_control_tb_top.sv
// Self-checking bench for the Type-C attach decode.
// Assumes the port controller model drives all indication pins.
`timescale 1ns/1ps
module typec_attach_phy_control_tb_top;
  import tca_pkg::*;
  logic       clk_i, rst_n_i, mode_r, pol_r, ext_r;
  logic [2:0] att_r, att_p;
  logic [1:0] ori_r, sa_r, sb_r, ori_p, sa_p, sb_p, phy_en_o, cfg_mode_o;
  logic       phy_clk_en_o, attach_valid_o, orientation_b_o;
  int         error_cnt, n_tests;

  tca_pc_model pc_u (.pol_i(pol_r), .att_i(att_r), .ori_i(ori_r), .sa_i(sa_r), .sb_i(sb_r),
    .att_o(att_p), .ori_o(ori_p), .sa_o(sa_p), .sb_o(sb_p));
  tca_attach_ctrl dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .attach_detect_i(att_p),
    .plug_orientation_in_i(ori_p), .mux_attach_side_in_a_i(sa_p),
    .mux_attach_side_in_b_i(sb_p), .internal_mux_mode_select_i(mode_r),
    .indication_polarity_select_i(pol_r), .ext_mux_config_i(ext_r), .phy_en_o(phy_en_o),
    .phy_clk_en_o(phy_clk_en_o), .attach_valid_o(attach_valid_o),
    .orientation_b_o(orientation_b_o), .cfg_mode_o(cfg_mode_o));

  // Free-running core clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compare every output; the clock gate must track the enables
  task automatic chk(input logic [1:0] ephy, input logic eori, input logic [1:0] ecfg);
    n_tests++;
    if ({phy_en_o, phy_clk_en_o, attach_valid_o, orientation_b_o, cfg_mode_o}
        !== {ephy, |ephy, |ephy, eori, ecfg}) begin
      $display("MISMATCH t=%0t phy=%b clk=%b val=%b ori=%b cfg=%b exp phy=%b ori=%b cfg=%b",
        $time, phy_en_o, phy_clk_en_o, attach_valid_o, orientation_b_o, cfg_mode_o,
        ephy, eori, ecfg);
      error_cnt++;
    end
  endtask

  // Apply one pin set off the sampling edge, wait out the fixed latency, then judge
  task automatic run(input logic e, m, input logic [2:0] a, input logic [1:0] o, sa, sb,
                     input logic [1:0] ephy, input logic eori, input logic [1:0] ecfg);
    @(negedge clk_i);
    {ext_r, mode_r, att_r, ori_r, sa_r, sb_r} = {e, m, a, o, sa, sb};
    repeat (4) @(negedge clk_i);
    chk(ephy, eori, ecfg);
  endtask

  // External mux: any attach bit gates lane A clock, stray side pins ignored
  task automatic t_ext();
    run(1'b1, 1'b1, 3'h1, 2'h2, 2'h0, 2'h3, PHY_A, 1'b0, CFG_EXT);
    run(1'b1, 1'b0, 3'h4, 2'h0, 2'h1, 2'h0, PHY_A, 1'b0, CFG_EXT);
    run(1'b1, 1'b0, 3'h0, 2'h1, 2'h1, 2'h0, PHY_NONE, 1'b0, CFG_EXT);
    run(1'b1, 1'b0, 3'h7, 2'h3, 2'h3, 2'h3, PHY_A, 1'b0, CFG_EXT);
  endtask

  // Mode 1: attach plus orientation, ambiguous orientation enables nothing
  task automatic t_mode1();
    run(1'b0, 1'b0, 3'h1, 2'h1, 2'h0, 2'h0, PHY_A, 1'b0, CFG_MODE1);
    run(1'b0, 1'b0, 3'h2, 2'h2, 2'h0, 2'h0, PHY_B, 1'b1, CFG_MODE1);
    run(1'b0, 1'b0, 3'h3, 2'h3, 2'h0, 2'h0, PHY_NONE, 1'b0, CFG_MODE1);
    run(1'b0, 1'b0, 3'h4, 2'h1, 2'h0, 2'h0, PHY_NONE, 1'b0, CFG_MODE1);
  endtask

  // Mode 2: side pins decide, attach pins have no say
  task automatic t_mode2();
    run(1'b0, 1'b1, 3'h0, 2'h0, 2'h1, 2'h0, PHY_A, 1'b0, CFG_MODE2);
    run(1'b0, 1'b1, 3'h7, 2'h1, 2'h0, 2'h2, PHY_B, 1'b1, CFG_MODE2);
    run(1'b0, 1'b1, 3'h7, 2'h0, 2'h2, 2'h1, PHY_NONE, 1'b0, CFG_MODE2);
    run(1'b0, 1'b1, 3'h7, 2'h2, 2'h0, 2'h0, PHY_NONE, 1'b0, CFG_MODE2);
  endtask

  // A flip must not reach the outputs one edge after it is sampled
  task automatic t_sync();
    run(1'b0, 1'b0, 3'h1, 2'h1, 2'h0, 2'h0, PHY_A, 1'b0, CFG_MODE1);
    ori_r = 2'h2;
    @(negedge clk_i);
    chk(PHY_A, 1'b0, CFG_MODE1);
    @(negedge clk_i);
    chk(PHY_A, 1'b0, CFG_MODE1);
    repeat (2) @(negedge clk_i);
    chk(PHY_B, 1'b1, CFG_MODE1);
  endtask

  // Mid-run reset clears at once; pins show again only from the third edge
  task automatic t_reset();
    run(1'b1, 1'b0, 3'h7, 2'h0, 2'h0, 2'h0, PHY_A, 1'b0, CFG_EXT);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk(PHY_NONE, 1'b0, CFG_MODE1);
    rst_n_i = 1'b1;
    repeat (2) begin
      @(negedge clk_i);
      chk(PHY_NONE, 1'b0, CFG_MODE1);
    end
    @(negedge clk_i);
    chk(PHY_A, 1'b0, CFG_EXT);
  endtask

  // Reset, then every configuration under both polarities
  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    {ext_r, mode_r, pol_r, att_r, ori_r, sa_r, sb_r} = '0;
    repeat (6) @(negedge clk_i);
    chk(PHY_NONE, 1'b0, CFG_MODE1);
    rst_n_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      pol_r = p[0];
      t_ext();
      t_mode1();
      t_mode2();
      t_sync();
      t_reset();
    end
    close_out();
  end
endmodule
